// file: core/dct_timer.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ns
// What this block does
// - eight-bit up-counter stepped by a 256 Hz tick; stages give 128 Hz to 1 Hz
// - events come only from falling edges of 32, 8, 2 and 1 Hz stages
// - each such falling edge sets its flag regardless of the mask
// - flag register: bit3 1 Hz, bit2 2 Hz, bit1 8 Hz, bit0 32 Hz
// - flag register ignores writes; flags are zero after reset
// - reading the flag register clears the flags that were read
// - mask register read/write, same layout, one enables, zero masks
// - all mask bits reset to zero, masked
// - count readable as low nibble (128..16 Hz) and high nibble (8..1 Hz)
// - writes to both count addresses are ignored
// - reset clears all eight counter stages
// - writing one to clear bit 1 zeroes the counter; reads return zero
// - a counter clear may set flags through stage falling edges
module dct_timer #(
   parameter int TICK_CYCLES = dct_pkg::TICK_CYCLES
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [13:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   output logic             watchdog_clear_strobe
);
   // apb slave phases
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_ACCESS = 3'b010,
      ST_DONE   = 3'b100
   } dct_bus_e;

   logic       tick;
   dct_bus_e   state;
   dct_bus_e   next_state;
   logic [7:0] count_stage_bits;
   logic [7:0] next_count;
   logic [3:0] flags;
   logic [3:0] next_flags;
   logic [3:0] enables;
   logic [3:0] next_enables;
   logic [31:0] next_prdata;
   logic       next_pready;
   logic       next_pslverr;
   logic       next_irq;
   logic       next_wd_strobe;
   logic       count_clear_strobe;
   logic [3:0] fall_events;
   logic       rd_flags;
   logic       hit;

   // selects the four interrupting stages in flag bit order
   function automatic logic [3:0] tap_bits(input logic [7:0] c);
      logic [3:0] t;
      t                  = '0;
      t[dct_pkg::BIT_32HZ] = c[dct_pkg::STAGE_32HZ];
      t[dct_pkg::BIT_8HZ]  = c[dct_pkg::STAGE_8HZ];
      t[dct_pkg::BIT_2HZ]  = c[dct_pkg::STAGE_2HZ];
      t[dct_pkg::BIT_1HZ]  = c[dct_pkg::STAGE_1HZ];
      return t;
   endfunction

   // byte address of a printed register index
   function automatic logic [13:0] reg_addr(input logic [11:0] idx);
      return {idx, 2'b00};
   endfunction

   dct_tick_div #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_div (
      .mclk (mclk),
      .rst  (rst),
      .tick (tick)
   );

   // access is taken in the second bus cycle and answered one cycle later
   wire take    = (state == ST_ACCESS);
   wire wr_take = take && pwrite;
   assign count_clear_strobe = wr_take && (paddr == reg_addr(dct_pkg::IDX_CLEAR))
                               && pwdata[dct_pkg::BIT_CNT_CLEAR];

   // counter: free running on the tick, cleared by software
   always_comb begin
      next_count = count_stage_bits;
      if (count_clear_strobe) begin
         next_count = dct_pkg::COUNT_RST;
      end else if (tick) begin
         next_count = count_stage_bits + 8'h01;
      end
   end

   // falling edges of the tapped stages, including those a clear causes
   assign fall_events = tap_bits(count_stage_bits) & ~tap_bits(next_count);

   // flags set on events, cleared by a read; set beats clear
   assign rd_flags = take && !pwrite && (paddr == reg_addr(dct_pkg::IDX_FLAGS));
   always_comb begin
      next_flags = flags;
      if (rd_flags) begin
         next_flags = flags & ~flags;
      end
      next_flags = next_flags | fall_events;
   end

   // mask register write
   always_comb begin
      next_enables = enables;
      if (wr_take && paddr == reg_addr(dct_pkg::IDX_ENABLES)) begin
         next_enables = pwdata[3:0];
      end
   end

   // interrupt level from flags and masks
   assign next_irq = |(next_flags & next_enables);

   // read mux, decode and answer
   always_comb begin
      next_state   = state;
      next_prdata  = prdata;
      next_pready  = 1'b0;
      next_pslverr = 1'b0;
      hit          = 1'b1;
      next_wd_strobe = 1'b0;
      case (state)
         ST_IDLE: begin
            if (psel && !penable) begin
               next_state = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            next_state  = ST_DONE;
            next_pready = 1'b1;
            next_prdata = '0;
            if (paddr == reg_addr(dct_pkg::IDX_FLAGS)) begin
               next_prdata[3:0] = flags;
            end else if (paddr == reg_addr(dct_pkg::IDX_ENABLES)) begin
               next_prdata[3:0] = enables;
            end else if (paddr == reg_addr(dct_pkg::IDX_COUNT_LO)) begin
               next_prdata[3:0] = count_stage_bits[3:0];
            end else if (paddr == reg_addr(dct_pkg::IDX_COUNT_HI)) begin
               next_prdata[3:0] = count_stage_bits[7:4];
            end else if (paddr == reg_addr(dct_pkg::IDX_CLEAR)) begin
               next_prdata[3:0] = 4'h0;
               next_wd_strobe   = pwrite && pwdata[dct_pkg::BIT_WD_CLEAR];
            end else begin
               hit = 1'b0;
            end
            next_pslverr = !hit;
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         state                 <= ST_IDLE;
         count_stage_bits      <= dct_pkg::COUNT_RST;
         flags                 <= dct_pkg::FLAGS_RST;
         enables               <= dct_pkg::ENABLES_RST;
         prdata                <= 32'h0000_0000;
         pready                <= 1'b0;
         pslverr               <= 1'b0;
         irq                   <= 1'b0;
         watchdog_clear_strobe <= 1'b0;
      end else begin
         state                 <= next_state;
         count_stage_bits      <= next_count;
         flags                 <= next_flags;
         enables               <= next_enables;
         prdata                <= next_prdata;
         pready                <= next_pready;
         pslverr               <= next_pslverr;
         irq                   <= next_irq;
         watchdog_clear_strobe <= next_wd_strobe;
      end
   end
endmodule

// file: core/dct_pkg.sv
// shared constants for the divided clock tick timer
package dct_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [11:0] IDX_FLAGS     = 12'hF00;
   localparam logic [11:0] IDX_ENABLES   = 12'hF10;
   localparam logic [11:0] IDX_COUNT_LO  = 12'hF20;
   localparam logic [11:0] IDX_COUNT_HI  = 12'hF21;
   localparam logic [11:0] IDX_CLEAR     = 12'hF76;
   localparam int          ADDR_W        = 14;

   // field positions
   localparam int BIT_32HZ      = 0;
   localparam int BIT_8HZ       = 1;
   localparam int BIT_2HZ       = 2;
   localparam int BIT_1HZ       = 3;
   localparam int BIT_CNT_CLEAR = 1;
   localparam int BIT_WD_CLEAR  = 0;
   localparam int STAGE_32HZ    = 2;
   localparam int STAGE_8HZ     = 4;
   localparam int STAGE_2HZ     = 6;
   localparam int STAGE_1HZ     = 7;

   // reset values
   localparam logic [3:0] FLAGS_RST   = 4'h0;
   localparam logic [3:0] ENABLES_RST = 4'h0;
   localparam logic [7:0] COUNT_RST   = 8'h00;

   // timing: system clock and counter input tick
   localparam int CLK_HZ      = 100_000_000;
   localparam int TICK_HZ     = 256;
   localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
   localparam int TICK_W      = 19;
endpackage

// file: core/dct_tick_div.sv
`timescale 1ns/1ns
// divides the system clock down to a one-cycle 256 Hz enable pulse
module dct_tick_div #(
   parameter int TICK_CYCLES = dct_pkg::TICK_CYCLES
) (
   input  wire logic mclk,
   input  wire logic rst,
   output logic      tick
);
   logic [dct_pkg::TICK_W-1:0] cnt;
   logic [dct_pkg::TICK_W-1:0] next_cnt;
   logic                       next_tick;

   // count up the period, pulse on wrap
   always_comb begin
      next_tick = 1'b0;
      if (cnt == dct_pkg::TICK_W'(TICK_CYCLES - 1)) begin
         next_cnt  = '0;
         next_tick = 1'b1;
      end else begin
         next_cnt = cnt + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt  <= '0;
         tick <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         tick <= next_tick;
      end
   end
endmodule

// file: dv/dct_props.sv
`timescale 1ns/1ns
// bus answer, read data and interrupt checks at the timer ports
module dct_props (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq,
   input wire logic        watchdog_clear_strobe
);
   localparam logic [13:0] AF = 14'h3C00;
   localparam logic [13:0] AC = 14'h3DD8;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // setup then access, and the cycle that ends a transfer
   sequence s_req; psel && !penable ##1 psel && penable; endsequence
   sequence s_end; psel && penable && pready; endsequence
   sequence s_rd; s_end ##0 !pwrite; endsequence
   // properties
   property p_answer; s_req |-> !pready ##1 pready; endproperty
   property p_upper; s_rd |-> prdata[31:4] == 28'h0; endproperty
   property p_clr_rd; s_rd ##0 paddr == AC |-> prdata == 32'h0; endproperty
   property p_unmap; s_end ##0 paddr[13:10] != 4'hF |-> pslverr; endproperty
   property p_reset; $fell(rst) |-> !irq && !pready; endproperty
   property p_rd_clr; s_rd ##0 paddr == AF |-> ##[1:2] !irq; endproperty
   property p_irq_fall; $fell(irq) |-> pready; endproperty
   property p_wd; watchdog_clear_strobe |-> $past(pwrite) && $past(paddr) == AC ##1 !watchdog_clear_strobe; endproperty
   a_answer: assert property (p_answer) else $error("no answer in second access cycle");
   a_upper: assert property (p_upper) else $error("read data upper bits set");
   a_clr_rd: assert property (p_clr_rd) else $error("clear register read nonzero");
   a_unmap: assert property (p_unmap) else $error("unmapped access without error");
   a_reset: assert property (p_reset) else $error("outputs active after reset");
   a_rd_clr: assert property (p_rd_clr) else $error("irq kept after flag read");
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without access");
   a_wd: assert property (p_wd) else $error("bad watchdog strobe");
endmodule
bind dct_timer dct_props u_props (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
   .watchdog_clear_strobe(watchdog_clear_strobe));

// file: dv/dct_cpu.sv
`timescale 1ns/1ns
// cpu model: never takes interrupts, so each access runs as with interrupts off
module dct_cpu (
   input  wire logic        mclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [13:0]      paddr,
   output logic [31:0]      pwdata
);
   logic err;
   initial {psel, penable, pwrite, paddr, pwdata, err} = '0;
   // one transfer from just after an edge; leaves one idle cycle behind
   task automatic xf(input logic w, input logic [11:0] i, input logic [3:0] d,
                     output logic [3:0] q);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {28'h0, d};
      @(posedge mclk) penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      q = prdata[3:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   // count read until a read agrees with the one before, the first with zero; a carry may split the nibbles
   task automatic rd_count(output logic [7:0] c);
      logic [8:0] a;
      a = 9'h100;
      c = 8'h00;
      while ({1'b0, c} !== a) begin
         a = {1'b0, c};
         xf(1'b0, 12'hF21, 4'h0, c[7:4]);
         xf(1'b0, 12'hF20, 4'h0, c[3:0]);
      end
   endtask
   // count clear with watchdog service, then flags read to drop stray events
   task automatic clr_count(output logic [3:0] f);
      logic [3:0] q;
      xf(1'b1, 12'hF76, 4'h3, q);
      xf(1'b0, 12'hF00, 4'h0, f);
   endtask
endmodule

// file: dv/tb.sv
`timescale 1ns/1ns
module tb;
   logic        mclk, rst, psel, penable, pwrite, pready, pslverr, irq, wd;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  c;
   logic [3:0]  q;
   int          bad_count = 0, samples_checked = 0, cyc = 0, wd_n = 0;
   // clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // short tick period keeps the run within a few thousand cycles
   dct_timer #(.TICK_CYCLES(200)) DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .watchdog_clear_strobe(wd));
   dct_cpu cpu (.mclk(mclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   // hang limit and watchdog strobe count
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      wd_n <= wd_n + int'(wd === 1'b1);
      if (cyc == 60_000) begin
         bad_count = bad_count + 1;
         stop_test();
      end
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // read-only and write-only places, unmapped address
   task automatic t_access();
      cpu.xf(1'b0, 12'hF00, 4'h0, q);
      chk("flags", 4'h0, q);
      cpu.xf(1'b0, 12'hF10, 4'h0, q);
      chk("enables", 4'h0, q);
      cpu.xf(1'b1, 12'hF10, 4'hA, q);
      cpu.xf(1'b0, 12'hF10, 4'h0, q);
      chk("enables", 4'hA, q);
      cpu.xf(1'b1, 12'hF00, 4'hF, q);
      cpu.xf(1'b0, 12'hF00, 4'h0, q);
      chk("flags", 4'h0, q);
      cpu.xf(1'b1, 12'hF20, 4'hF, q);
      cpu.xf(1'b1, 12'hF21, 4'hF, q);
      cpu.rd_count(c);
      chk("count", 8'h00, c);
      cpu.xf(1'b0, 12'hF76, 4'h0, q);
      chk("clear", 4'h0, q);
      cpu.xf(1'b1, 12'h000, 4'h0, q);
      chk("slverr", 1'b1, cpu.err);
      chk("irq", 1'b0, irq);
      cpu.xf(1'b1, 12'hF10, 4'h0, q);
      $display("test access done");
   endtask
   // first 32 Hz falling edge at count 8 sets only its flag, while masked
   task automatic t_event();
      c = 8'h00;
      while (c !== 8'h08) cpu.rd_count(c);
      chk("irq masked", 1'b0, irq);
      cpu.xf(1'b1, 12'hF10, 4'h1, q);
      repeat (2) @(posedge mclk);
      chk("irq", 1'b1, irq);
      cpu.xf(1'b0, 12'hF00, 4'h0, q);
      chk("flags", 4'h1, q);
      repeat (2) @(posedge mclk);
      chk("irq", 1'b0, irq);
      cpu.xf(1'b0, 12'hF00, 4'h0, q);
      chk("flags", 4'h0, q);
      $display("test event done");
   endtask
   // clear right after a tick from 8 or 9: only untapped stages fall, so no flag
   task automatic t_clear();
      logic [7:0] c0;
      cpu.rd_count(c0);
      c = c0;
      while (c === c0) cpu.rd_count(c);
      cpu.clr_count(q);
      chk("flags", 4'h0, q);
      cpu.rd_count(c);
      chk("count", 8'h00, c);
      chk("wd strobes", 8'h01, wd_n[7:0]);
      $display("test clear done");
   endtask
   // reset, then scenarios
   initial begin
      rst = 1'b1;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      t_access();
      t_event();
      t_clear();
      stop_test();
   end
endmodule
